//--- core/rpsc_top.sv
/*
  Configuration register bank of the sub-GHz radio core, AXI4-Lite slave.
  Assumes a 100 MHz aclk, synchronous active-low reset and inputs that are
  synchronous to aclk. Register byte address is four times its index.
*/
// Added by the designer: the AXI4-Lite register port.
//
// Behaviour
// - Bit 6 switches data whitening on or off.
// - Format 00 normal, 10 sends PN9 test data.
// - Receive path ignores the test transmit format.
// - CRC bit enables transmit append and receive check.
// - Length mode 00 uses fixed register length.
// - Length mode 01 takes first byte after sync.
// - Device address compared with received addresses.
// - Channel times spacing added to base frequency.
// - IF word subtracted from base during receive.
// - Signed offset word added to base frequency.
// - 24-bit base word in three bytes, top two bits read-only.
// - Bandwidth exponent and mantissa set decimation ratio.
// - Low four modem bits hold symbol-rate exponent.
// - Packet size gives exact or maximum length.
// - Address filter mode selects broadcast acceptance.
`timescale 1ns/1ps
module rpsc_top
  import rpsc_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [AXI_AW-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [AXI_DW-1:0]     s_axi_wdata,
  input  wire logic [AXI_DW/8-1:0]   s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_AW-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [AXI_DW-1:0]          s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  rx_active,
  input  wire logic [15:0]           rf_slot_index_spacing,
  input  wire logic                  tx_bit_req,
  input  wire logic                  tx_payload_bit,
  input  wire logic                  rx_len_valid,
  input  wire logic [7:0]            rx_len_byte,
  input  wire logic                  rx_addr_valid,
  input  wire logic [7:0]            rx_addr,
  output rpsc_cfg_s                  cfg,
  output logic [23:0]                synth_word,
  output logic [4:0]                 intermediate_offset_word,
  output logic [6:0]                 decimation_ratio,
  output logic                       tx_bit,
  output logic                       crc_append,
  output logic                       crc_check,
  output logic                       len_valid,
  output logic                       len_ok,
  output logic [7:0]                 len_expected,
  output logic                       addr_result_valid,
  output logic                       addr_accept
);
  import rpsc_pkg::*;

  logic [7:0]        pkt_size_reg;
  logic [7:0]        pkt_ctrl1_reg;
  logic [7:0]        pkt_ctrl0_reg;
  logic [7:0]        dev_addr_reg;
  logic [7:0]        rf_slot_index_num_reg;
  logic [7:0]        synth_if_reg;
  logic [7:0]        synth_off_reg;
  logic [7:0]        carr_high_reg;
  logic [7:0]        carr_mid_reg;
  logic [7:0]        carr_low_reg;
  logic [7:0]        modem_bw_reg;
  logic              aw_have_reg;
  logic              w_have_reg;
  logic [AXI_AW-1:0] aw_addr_reg;
  logic [7:0]        w_byte_reg;
  logic              w_lane0_reg;
  logic              do_write;
  logic [15:0]       wr_idx;
  logic [15:0]       rd_idx;
  logic [7:0]        rd_byte;
  logic              rd_hit;
  logic [1:0]        fmt;
  logic [1:0]        lencfg;
  logic              pn9_bit;
  logic              pn9_on;
  logic [25:0]       carrier_base_word_next;
  logic [23:0]       rf_slot_index_product;
  logic [23:0]       base_word;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order.

  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wr_idx   = aw_addr_reg[AXI_AW-1:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg   <= 1'b0;
      aw_addr_reg   <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg   <= 1'b1;
      aw_addr_reg   <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_have_reg   <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg   <= 1'b0;
      w_byte_reg   <= 8'h00;
      w_lane0_reg  <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg   <= 1'b1;
      w_byte_reg   <= s_axi_wdata[7:0];
      w_lane0_reg  <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_have_reg   <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_idx >= IDX_PKT_SIZE && wr_idx <= IDX_MODEM_BW) ?
                      RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage; masks keep read-only and unused bits at reset value.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pkt_size_reg  <= RST_PKT_SIZE;
      pkt_ctrl1_reg <= RST_PKT_CTRL1;
      pkt_ctrl0_reg <= RST_PKT_CTRL0;
      dev_addr_reg  <= RST_DEV_ADDR;
      rf_slot_index_num_reg  <= RST_RF_SLOT_INDEX_NUM;
      synth_if_reg  <= RST_SYNTH_IF;
      synth_off_reg <= RST_SYNTH_OFF;
      carr_high_reg <= RST_CARR_HIGH;
      carr_mid_reg  <= RST_CARR_MID;
      carr_low_reg  <= RST_CARR_LOW;
      modem_bw_reg  <= RST_MODEM_BW;
    end else if (do_write && w_lane0_reg) begin
      unique case (wr_idx)
        IDX_PKT_SIZE:  pkt_size_reg  <= w_byte_reg;
        IDX_PKT_CTRL1: pkt_ctrl1_reg <= w_byte_reg & WMASK_CTRL1;
        IDX_PKT_CTRL0: pkt_ctrl0_reg <= w_byte_reg & WMASK_CTRL0;
        IDX_DEV_ADDR:  dev_addr_reg  <= w_byte_reg;
        IDX_RF_SLOT_INDEX_NUM:  rf_slot_index_num_reg  <= w_byte_reg;
        IDX_SYNTH_IF:  synth_if_reg  <= w_byte_reg & WMASK_SYNTH_IF;
        IDX_SYNTH_OFF: synth_off_reg <= w_byte_reg;
        IDX_CARR_HIGH: carr_high_reg <= (w_byte_reg & WMASK_CARR_HI) |
                                        (RST_CARR_HIGH & ~WMASK_CARR_HI);
        IDX_CARR_MID:  carr_mid_reg  <= w_byte_reg;
        IDX_CARR_LOW:  carr_low_reg  <= w_byte_reg;
        IDX_MODEM_BW:  modem_bw_reg  <= w_byte_reg;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one cycle from address to data; unmapped gives SLVERR.

  assign rd_idx = s_axi_araddr[AXI_AW-1:2];

  always_comb begin
    rd_hit = 1'b1;
    unique case (rd_idx)
      IDX_PKT_SIZE:  rd_byte = pkt_size_reg;
      IDX_PKT_CTRL1: rd_byte = pkt_ctrl1_reg;
      IDX_PKT_CTRL0: rd_byte = pkt_ctrl0_reg;
      IDX_DEV_ADDR:  rd_byte = dev_addr_reg;
      IDX_RF_SLOT_INDEX_NUM:  rd_byte = rf_slot_index_num_reg;
      IDX_SYNTH_IF:  rd_byte = synth_if_reg;
      IDX_SYNTH_OFF: rd_byte = synth_off_reg;
      IDX_CARR_HIGH: rd_byte = carr_high_reg;
      IDX_CARR_MID:  rd_byte = carr_mid_reg;
      IDX_CARR_LOW:  rd_byte = carr_low_reg;
      IDX_MODEM_BW:  rd_byte = modem_bw_reg;
      default: begin
        rd_byte = 8'h00;
        rd_hit  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded configuration for the packet engine and modem.

  assign fmt    = pkt_ctrl0_reg[POS_FORMAT +: 2];
  assign lencfg = pkt_ctrl0_reg[POS_LENCFG +: 2];
  assign pn9_on = fmt == FMT_PN9;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= '0;
    end else begin
      cfg.whitening_enable     <= pkt_ctrl0_reg[BIT_WHITEN];
      cfg.crc_enable           <= pkt_ctrl0_reg[BIT_CRC];
      cfg.pn9_tx               <= pn9_on;
      cfg.fixed_length         <= lencfg == LEN_FIXED;
      cfg.address_filter_mode  <= pkt_ctrl1_reg[1:0];
      cfg.packet_size          <= pkt_size_reg;
      cfg.device_address       <= dev_addr_reg;
      cfg.filter_bw_exponent   <= modem_bw_reg[POS_BW_EXP +: 2];
      cfg.filter_bw_mantissa   <= modem_bw_reg[POS_BW_MANT +: 2];
      cfg.symbol_rate_exponent <= modem_bw_reg[POS_RATE_EXP +: 4];
    end
  end

  // Ratio is (4 + mantissa) * 2^exponent, in decimation steps.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      decimation_ratio <= '0;
    end else begin
      decimation_ratio <= 7'({3'd4 + 3'(modem_bw_reg[POS_BW_MANT +: 2])}
                          << modem_bw_reg[POS_BW_EXP +: 2]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synthesizer word in steps of fref / 2^16.

  assign base_word    = {carr_high_reg, carr_mid_reg, carr_low_reg};
  assign rf_slot_index_product = 24'(rf_slot_index_num_reg * rf_slot_index_spacing);

  always_comb begin
    carrier_base_word_next = {2'b00, base_word} + {2'b00, rf_slot_index_product}
              + 26'({{18{synth_off_reg[7]}}, synth_off_reg} << OFF_SHIFT)
              - (rx_active ? 26'({21'h00_0000, synth_if_reg[4:0]} << IF_SHIFT)
                           : 26'h000_0000);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      synth_word               <= '0;
      intermediate_offset_word <= '0;
    end else begin
      synth_word               <= carrier_base_word_next[23:0];
      intermediate_offset_word <= synth_if_reg[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit bit source: PN9 in test format, payload otherwise.

  rpsc_pn9 #(
    .WIDTH (9),
    .SEED  (PN9_SEED)
  ) u_pn9 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (pn9_on),
    .step    (tx_bit_req),
    .bit_out (pn9_bit)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_bit     <= 1'b0;
      crc_append <= 1'b0;
      crc_check  <= 1'b0;
    end else begin
      tx_bit     <= pn9_on ? pn9_bit : tx_payload_bit;
      crc_append <= pkt_ctrl0_reg[BIT_CRC];
      crc_check  <= pkt_ctrl0_reg[BIT_CRC];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive length check; independent of the transmit format.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      len_valid    <= 1'b0;
      len_ok       <= 1'b0;
      len_expected <= 8'h00;
    end else if (lencfg == LEN_FIXED) begin
      len_valid    <= 1'b1;
      len_ok       <= 1'b1;
      len_expected <= pkt_size_reg;
    end else begin
      len_valid    <= rx_len_valid;
      len_ok       <= rx_len_valid && rx_len_byte <= pkt_size_reg;
      len_expected <= rx_len_valid ? rx_len_byte : len_expected;
    end
  end

  rpsc_addr_filter u_addr_filter (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .addr_valid     (rx_addr_valid),
    .rx_addr        (rx_addr),
    .device_address (dev_addr_reg),
    .mode           (pkt_ctrl1_reg[1:0]),
    .result_valid   (addr_result_valid),
    .accept         (addr_accept)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  sequence s_write_done;
    aw_have_reg && w_have_reg && !s_axi_bvalid;
  endsequence

  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_done |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write response missing");
  a_read_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data missing");
  a_carrier_top_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
    carr_high_reg[7:6] == RST_CARR_HIGH[7:6])
    else $error("carrier top bits changed");
  a_crc_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn |=> crc_append == $past(pkt_ctrl0_reg[BIT_CRC]))
    else $error("crc enable not applied");
  a_whiten_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn |=> cfg.whitening_enable ==
                $past(pkt_ctrl0_reg[BIT_WHITEN]))
    else $error("whitening enable not applied");
  a_tx_payload: assert property (@(posedge aclk) disable iff (!aresetn)
    fmt == FMT_NORMAL |=> tx_bit == $past(tx_payload_bit))
    else $error("normal format bit not passed");
  a_len_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
    lencfg == LEN_FIXED |=> len_expected == $past(pkt_size_reg))
    else $error("fixed length not from size");
  a_len_var_max: assert property (@(posedge aclk) disable iff (!aresetn)
    lencfg == LEN_VARIABLE && rx_len_valid && rx_len_byte > pkt_size_reg
    |=> !len_ok)
    else $error("oversize length accepted");
  a_rate_exp: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn |=> cfg.symbol_rate_exponent ==
                $past(modem_bw_reg[3:0]))
    else $error("rate exponent mismatch");
  a_synth_rx: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_active && synth_off_reg == 8'h00 && rf_slot_index_num_reg == 8'h00
    |=> synth_word == 24'($past(base_word) - ($past(synth_if_reg[4:0])
        << IF_SHIFT)))
    else $error("IF not subtracted in receive");
endmodule

//--- core/rpsc_pkg.sv
/*
  Package of the radio packet and synthesizer configuration bank: register
  indices, reset values, write masks, field positions and the config struct.
  Assumes byte address equals four times the register index.
*/
package rpsc_pkg;
  localparam int          AXI_AW         = 18;
  localparam int          AXI_DW         = 32;
  localparam logic [15:0] IDX_PKT_SIZE   = 16'hdf02;
  localparam logic [15:0] IDX_PKT_CTRL1  = 16'hdf03;
  localparam logic [15:0] IDX_PKT_CTRL0  = 16'hdf04;
  localparam logic [15:0] IDX_DEV_ADDR   = 16'hdf05;
  localparam logic [15:0] IDX_RF_SLOT_INDEX_NUM   = 16'hdf06;
  localparam logic [15:0] IDX_SYNTH_IF   = 16'hdf07;
  localparam logic [15:0] IDX_SYNTH_OFF  = 16'hdf08;
  localparam logic [15:0] IDX_CARR_HIGH  = 16'hdf09;
  localparam logic [15:0] IDX_CARR_MID   = 16'hdf0a;
  localparam logic [15:0] IDX_CARR_LOW   = 16'hdf0b;
  localparam logic [15:0] IDX_MODEM_BW   = 16'hdf0c;
  localparam logic [7:0]  RST_PKT_SIZE   = 8'hff;
  localparam logic [7:0]  RST_PKT_CTRL1  = 8'h00;
  localparam logic [7:0]  RST_PKT_CTRL0  = 8'h45;
  localparam logic [7:0]  RST_DEV_ADDR   = 8'h00;
  localparam logic [7:0]  RST_RF_SLOT_INDEX_NUM   = 8'h00;
  localparam logic [7:0]  RST_SYNTH_IF   = 8'h0f;
  localparam logic [7:0]  RST_SYNTH_OFF  = 8'h00;
  localparam logic [7:0]  RST_CARR_HIGH  = 8'h5e;
  localparam logic [7:0]  RST_CARR_MID   = 8'hc4;
  localparam logic [7:0]  RST_CARR_LOW   = 8'hec;
  localparam logic [7:0]  RST_MODEM_BW   = 8'h8c;
  localparam logic [7:0]  WMASK_CTRL1    = 8'h03;
  localparam logic [7:0]  WMASK_CTRL0    = 8'h7f;
  localparam logic [7:0]  WMASK_SYNTH_IF = 8'h3f;
  localparam logic [7:0]  WMASK_CARR_HI  = 8'h3f;
  localparam int          BIT_WHITEN     = 6;
  localparam int          POS_FORMAT     = 4;
  localparam int          BIT_CRC        = 2;
  localparam int          POS_LENCFG     = 0;
  localparam int          POS_BW_EXP     = 6;
  localparam int          POS_BW_MANT    = 4;
  localparam int          POS_RATE_EXP   = 0;
  localparam int          IF_SHIFT       = 6;
  localparam int          OFF_SHIFT      = 2;
  localparam logic [1:0]  FMT_NORMAL     = 2'h0;
  localparam logic [1:0]  FMT_PN9        = 2'h2;
  localparam logic [1:0]  LEN_FIXED      = 2'h0;
  localparam logic [1:0]  LEN_VARIABLE   = 2'h1;
  localparam logic [1:0]  FILT_NONE      = 2'h0;
  localparam logic [1:0]  FILT_NO_BCAST  = 2'h1;
  localparam logic [1:0]  FILT_BCAST0    = 2'h2;
  localparam logic [1:0]  FILT_BCAST0FF  = 2'h3;
  localparam logic [7:0]  BCAST_ZERO     = 8'h00;
  localparam logic [7:0]  BCAST_ONES     = 8'hff;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [8:0]  PN9_SEED       = 9'h1ff;

  typedef struct packed {
    logic       whitening_enable;
    logic       crc_enable;
    logic       pn9_tx;
    logic       fixed_length;
    logic [1:0] address_filter_mode;
    logic [7:0] packet_size;
    logic [7:0] device_address;
    logic [1:0] filter_bw_exponent;
    logic [1:0] filter_bw_mantissa;
    logic [3:0] symbol_rate_exponent;
  } rpsc_cfg_s;
endpackage

//--- core/rpsc_pn9.sv
/*
  Nine-bit pseudo-random generator, polynomial x^9 + x^5 + 1.
  Assumes step is a one-cycle request for the next bit.
*/
`timescale 1ns/1ps
module rpsc_pn9 #(
  parameter int          WIDTH = 9,
  parameter logic [8:0]  SEED  = 9'h1ff
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic enable,
  input  wire logic step,
  output logic      bit_out
);
  logic [WIDTH-1:0] lfsr_reg;

  // Reloads the seed while enable is low so each test burst starts the same.
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      lfsr_reg <= SEED;
    end else if (step) begin
      lfsr_reg <= {lfsr_reg[0] ^ lfsr_reg[5], lfsr_reg[WIDTH-1:1]};
    end
  end

  assign bit_out = lfsr_reg[0];

  a_pn9_shift: assert property (@(posedge aclk) disable iff (!aresetn)
    enable && step && $past(enable) |=> lfsr_reg[7:0] == $past(lfsr_reg[8:1]))
    else $error("pn9 register did not shift");
endmodule

//--- core/rpsc_addr_filter.sv
/*
  Received address filter against the device address, with broadcast modes.
  Assumes addr_valid is a one-cycle strobe carrying rx_addr.
*/
`timescale 1ns/1ps
module rpsc_addr_filter
  import rpsc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       addr_valid,
  input  wire logic [7:0] rx_addr,
  input  wire logic [7:0] device_address,
  input  wire logic [1:0] mode,
  output logic            result_valid,
  output logic            accept
);
  logic hit;

  always_comb begin
    unique case (mode)
      FILT_NONE:     hit = 1'b1;
      FILT_NO_BCAST: hit = rx_addr == device_address;
      FILT_BCAST0:   hit = rx_addr == device_address || rx_addr == BCAST_ZERO;
      FILT_BCAST0FF: hit = rx_addr == device_address ||
                           rx_addr == BCAST_ZERO || rx_addr == BCAST_ONES;
    endcase
  end

  // Registers the decision one cycle after the strobe.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_valid <= 1'b0;
      accept       <= 1'b0;
    end else begin
      result_valid <= addr_valid;
      accept       <= addr_valid && hit;
    end
  end

  a_filter_bcast: assert property (@(posedge aclk) disable iff (!aresetn)
    addr_valid && mode == FILT_BCAST0FF && rx_addr == BCAST_ONES
    |=> accept)
    else $error("broadcast 0xFF not accepted");
endmodule

//--- tb/rpsc_bench.sv
/* Self-checking bench of the configuration bank.
   Assumes the bank is an AXI4-Lite slave clocked by aclk. */
`timescale 1ns/1ps
module rpsc_bench;
  import rpsc_pkg::*;
  logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [AXI_DW-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = '0;
  logic [15:0]       rf_slot_index_spacing = '0;
  logic [7:0]        rx_len_byte = '0, rx_addr = '0, len_expected;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [23:0]       synth_word;
  logic [6:0]        decimation_ratio;
  logic [4:0]        intermediate_offset_word;
  rpsc_cfg_s         cfg;
  logic              aclk = 0, aresetn = 0, s_axi_awvalid = 0;
  logic              s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic              s_axi_rready = 0, rx_active = 0, tx_bit_req = 0;
  logic              tx_payload_bit = 0, rx_len_valid = 0, rx_addr_valid = 0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic              s_axi_rvalid, tx_bit, crc_append, crc_check, len_valid;
  logic              len_ok, addr_result_valid, addr_accept;
  int                miscompares = 0, checks = 0;

  rpsc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .rx_active, .rf_slot_index_spacing, .tx_bit_req, .tx_payload_bit, .rx_len_valid,
    .rx_len_byte, .rx_addr_valid, .rx_addr, .cfg, .synth_word,
    .intermediate_offset_word, .decimation_ratio, .tx_bit, .crc_append,
    .crc_check, .len_valid, .len_ok, .len_expected, .addr_result_valid,
    .addr_accept);

  always #5 aclk = ~aclk;
////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Performs one bus write (w=1) or read and waits for the answer.
  task automatic acc(input bit w, input logic [15:0] a, input logic [7:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    bit got;
    got = 0;
    @(posedge aclk);
    if (w) begin
      s_axi_awaddr <= {a, 2'b00};
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
    end else begin
      s_axi_araddr <= {a, 2'b00};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
    end
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_bvalid && s_axi_bready) begin
        got = 1;
        r = s_axi_bresp;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        got = 1;
        r = s_axi_rresp;
        q = s_axi_rdata;
      end
    end
    s_axi_bready <= 0;
    s_axi_rready <= 0;
    if (!got) begin
      miscompares++;
      $display("ERROR %0t: bus timeout", $time);
      wrap_up();
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic [1:0]  r;
    acc(1, a, d, q, r);
  endtask

  task automatic settle();
    repeat (3) @(posedge aclk);
    #1;
  endtask

  task automatic rxp(input bit adr, input logic [7:0] b);
    @(posedge aclk);
    rx_len_valid <= !adr;
    rx_addr_valid <= adr;
    rx_len_byte <= b;
    rx_addr <= b;
    @(posedge aclk);
    rx_len_valid <= 0;
    rx_addr_valid <= 0;
    #1;
  endtask
////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [15:0] ia [11] = '{IDX_PKT_SIZE, IDX_PKT_CTRL1, IDX_PKT_CTRL0,
      IDX_DEV_ADDR, IDX_RF_SLOT_INDEX_NUM, IDX_SYNTH_IF, IDX_SYNTH_OFF, IDX_CARR_HIGH,
      IDX_CARR_MID, IDX_CARR_LOW, IDX_MODEM_BW};
    logic [7:0]  rv [11] = '{8'hff, 8'h00, 8'h45, 8'h00, 8'h00, 8'h0f,
      8'h00, 8'h5e, 8'hc4, 8'hec, 8'h8c};
    logic [15:0] ma [4] = '{IDX_CARR_HIGH, IDX_PKT_CTRL1, IDX_SYNTH_IF,
      IDX_PKT_CTRL0};
    logic [7:0]  mv [4] = '{8'h7f, 8'h03, 8'h3f, 8'h7f};
    logic [31:0] q;
    logic [1:0]  r;
    foreach (ia[i]) begin
      acc(0, ia[i], 8'h00, q, r);
      chk(q, {24'h00_0000, rv[i]});
    end
    chk({synth_word, decimation_ratio}, {24'h5e_c4ec, 7'h10});
    foreach (ma[i]) begin
      wr(ma[i], 8'hff);
      acc(0, ma[i], 8'h00, q, r);
      chk(q, {24'h00_0000, mv[i]});
    end
    settle();
    chk(intermediate_offset_word, 5'h1f);
    acc(0, 16'hdf0d, 8'h00, q, r);
    chk({q[29:0], r}, {30'h0000_0000, RESP_SLVERR});
    acc(1, 16'h0000, 8'h5a, q, r);
    chk(r, RESP_SLVERR);
    $display("test registers done");
  endtask

  task automatic t_pkt();
    logic [8:0] p = PN9_SEED;
    wr(IDX_PKT_SIZE, 8'h20);
    wr(IDX_PKT_CTRL0, 8'h04);
    settle();
    chk({cfg.whitening_enable, cfg.pn9_tx, cfg.crc_enable, crc_append,
         crc_check, cfg.fixed_length, len_valid, len_ok, len_expected,
         cfg.packet_size}, {8'h3f, 8'h20, 8'h20});
    for (int b = 1; b >= 0; b--) begin
      @(posedge aclk);
      tx_payload_bit <= b[0];
      @(posedge aclk);
      #1;
      chk(tx_bit, b[0]);
    end
    wr(IDX_PKT_CTRL0, 8'h61);
    settle();
    chk({cfg.whitening_enable, cfg.pn9_tx, cfg.crc_enable, crc_append,
         crc_check, cfg.fixed_length}, 6'h30);
    rxp(0, 8'h20);
    chk({len_valid, len_ok}, 2'h3);
    rxp(0, 8'h21);
    chk({len_valid, len_ok}, 2'h2);
    @(posedge aclk);
    tx_bit_req <= 1;
    for (int i = 0; i < 16; i++) begin
      @(posedge aclk);
      #1;
      chk(tx_bit, p[0]);
      p = {p[0] ^ p[5], p[8:1]};
    end
    @(posedge aclk);
    tx_bit_req <= 0;
    $display("test packet done");
  endtask

  task automatic t_addr();
    logic [7:0] av [4] = '{8'h5a, 8'h00, 8'hff, 8'h33};
    bit         e;
    wr(IDX_DEV_ADDR, 8'h5a);
    for (int m = 0; m < 4; m++) begin
      wr(IDX_PKT_CTRL1, 8'(m));
      settle();
      chk({cfg.device_address, cfg.address_filter_mode},
          {8'h5a, 2'(m)});
      foreach (av[i]) begin
        e = m == 0 || av[i] == 8'h5a || (m > 1 && av[i] == 8'h00) ||
            (m == 3 && av[i] == 8'hff);
        rxp(1, av[i]);
        chk({addr_result_valid, addr_accept}, {1'b1, e});
      end
    end
    $display("test address done");
  endtask

  task automatic t_synth();
    logic [23:0] e;
    logic [7:0]  off = 8'hfe;
    logic [4:0]  ifw = 5'h0a;
    wr(IDX_CARR_HIGH, 8'h12);
    wr(IDX_CARR_MID, 8'h34);
    wr(IDX_CARR_LOW, 8'h56);
    wr(IDX_RF_SLOT_INDEX_NUM, 8'h03);
    wr(IDX_SYNTH_OFF, off);
    wr(IDX_SYNTH_IF, {3'h0, ifw});
    rf_slot_index_spacing <= 16'h0100;
    for (int x = 0; x < 2; x++) begin
      @(posedge aclk);
      rx_active <= x[0];
      settle();
      e = 24'h52_3456 + 24'h00_0300 + {{14{off[7]}}, off, 2'b00};
      if (x == 1) e = e - {13'h0000, ifw, 6'h00};
      chk(synth_word, e);
    end
    wr(IDX_RF_SLOT_INDEX_NUM, 8'h00);
    wr(IDX_SYNTH_OFF, 8'h00);
    settle();
    chk(synth_word, 24'h52_3456 - {13'h0000, ifw, 6'h00});
    $display("test synth done");
  endtask

  task automatic t_bw();
    logic [1:0] m;
    logic [3:0] s;
    for (int e = 0; e < 4; e++) begin
      m = 2'(3 - e);
      s = 4'(e * 5);
      wr(IDX_MODEM_BW, {2'(e), m, s});
      settle();
      chk(decimation_ratio, 7'((4 + m) << e));
      chk({cfg.filter_bw_exponent, cfg.filter_bw_mantissa,
           cfg.symbol_rate_exponent}, {2'(e), m, s});
    end
    $display("test bandwidth done");
  endtask
////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    t_regs();
    t_pkt();
    t_addr();
    t_synth();
    t_bw();
    wrap_up();
  end
endmodule
